// file: logic/flash_array_access_control.sv
// program flash access: ahb-lite read window, page buffer, erase/program sequencer
// assumes: ahb-lite master on clk; command port driven by logic on the same clock
`include "flash_cfg.svh"
// Operation
// - thirty-two 1 kB sectors, per-sector operations
// - sector is 16 rows of 16 words
// - only the low 30 kB usable
// - ahb reads over one contiguous region
// - read words are little endian
// - ahb writes only fill page buffer
// - erase and program are separate operations
// - modify only unprotected, unlocked sectors; a program taken as a buffer write closes checks the old row's sector
// - refused operations raise no error
// - all sectors protected after reset
// - lock bit sets, never clears
// - locked sector never erased; programmed only if a buffer write into it closes as the program is taken
module flash_array_access_control
   import flash_pkg::*;
#(
   parameter int USABLE_SECTORS = `FL_USABLE_SECTORS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [`FL_ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [`FL_DATA_W-1:0] hwdata,
   input wire logic hready,
   input wire cmd_t cmd,
   output logic hreadyout,
   output logic hresp,
   output logic [`FL_DATA_W-1:0] hrdata,
   output logic busy,
   output logic [`FL_SECTORS-1:0] prot_state,
   output logic [`FL_SECTORS-1:0] lock_state
);
   localparam state_t ST_RST = '{
      seq: SEQ_IDLE,
      cnt: '0,
      sector: '0,
      prot: `FL_PROT_RESET,
      lock: `FL_LOCK_RESET,
      busy: 1'b0,
      hreadyout: 1'b1,
      hresp: 1'b0,
      dph_act: 1'b0,
      dph_wr: 1'b0,
      dph_addr: '0,
      dph_be: '0,
      buf_row: '0,
      pbuf: {`FL_WORDS{`FL_ERASED}}
   };
   localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(`FL_ROWS * `FL_WORDS - 1);
   localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(`FL_WORDS - 1);

   if (USABLE_SECTORS < 1 || USABLE_SECTORS > `FL_SECTORS) begin : g_chk
      $error("flash_array_access_control: USABLE_SECTORS out of range");
   end
   if (`FL_ADDR_W != WIDX_W + `FL_WORD_LSB || `FL_DATA_W != 32) begin : g_chk_geo
      $error("flash_array_access_control: address or data width mismatch");
   end

   state_t s_q;
   state_t s_d;
   logic acc;
   logic [WIDX_W-1:0] widx;
   logic [SECT_W-1:0] psect;
   logic mem_en;
   logic mem_we;
   logic mem_clr;
   logic [WIDX_W-1:0] mem_addr;
   logic [`FL_DATA_W-1:0] mem_wdata;

   // sectors above the usable window are never erased; programmed only via a buffer write closing as program is taken
   function automatic logic usable(input logic [SECT_W-1:0] sec);
      return {1'b0, sec} < (SECT_W + 1)'(USABLE_SECTORS);
   endfunction

   function automatic logic allowed(input state_t s, input logic [SECT_W-1:0] sec);
      return usable(sec) && !s.prot[sec] && !s.lock[sec];
   endfunction

   function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] a);
      logic [3:0] be;
      be = 4'hf;
      if (sz == 3'h0) begin
         be = 4'(4'h1 << a);
      end else if (sz == 3'h1) begin
         be = a[1] ? 4'hc : 4'h3;
      end
      return be;
   endfunction

   // hready is looped back, so no address phase is taken while the sequencer stalls
   assign acc = hsel && htrans[1] && hready;
   assign widx = haddr[`FL_ADDR_W-1:`FL_WORD_LSB];
   assign psect = s_q.buf_row[SECT_W+ROW_W-1:ROW_W];

   always_comb begin
      s_d = s_q;
      mem_en = 1'b0;
      mem_we = 1'b0;
      mem_clr = 1'b0;
      mem_addr = widx;
      mem_wdata = `FL_ERASED;

      // close a write data phase into the page buffer, never the array
      if (s_q.dph_act && s_q.dph_wr && s_q.hreadyout) begin
         for (int b = 0; b < 4; b++) begin
            if (s_q.dph_be[b]) begin
               s_d.pbuf[s_q.dph_addr[WORD_W-1:0]][8*b +: 8] = hwdata[8*b +: 8];
            end
         end
         s_d.buf_row = s_q.dph_addr[WIDX_W-1:WORD_W];
      end

      if (hready) begin
         s_d.dph_act = acc;
      end
      if (acc) begin
         s_d.dph_wr = hwrite;
         s_d.dph_addr = widx;
         s_d.dph_be = lanes(hsize, haddr[1:0]);
         if (!hwrite) begin
            // word read lands in the read register for the data phase
            mem_en = 1'b1;
            mem_clr = !usable(widx[WIDX_W-1:CNT_W]);
         end
      end

      unique case (s_q.seq)
         SEQ_IDLE: begin
            if (cmd.valid) begin
               case (cmd.op)
                  OP_UNPROTECT: s_d.prot[cmd.sector] = 1'b0;
                  OP_PROTECT: s_d.prot[cmd.sector] = 1'b1;
                  OP_LOCK: s_d.lock[cmd.sector] = 1'b1;
                  OP_ERASE: begin
                     // refused sectors are dropped silently, no flag
                     if (allowed(s_q, cmd.sector)) begin
                        s_d.seq = SEQ_ERASE;
                        s_d.sector = cmd.sector;
                        s_d.cnt = '0;
                        s_d.busy = 1'b1;
                        s_d.hreadyout = 1'b0;
                     end
                  end
                  OP_PROGRAM: begin
                     if (allowed(s_q, psect)) begin
                        s_d.seq = SEQ_PROG;
                        s_d.cnt = '0;
                        s_d.busy = 1'b1;
                        s_d.hreadyout = 1'b0;
                     end
                  end
                  default: ;
               endcase
            end
         end
         SEQ_ERASE: begin
            // one word per cycle over the sector's rows and words
            mem_en = 1'b1;
            mem_we = 1'b1;
            mem_addr = {s_q.sector, s_q.cnt};
            mem_wdata = `FL_ERASED;
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == ERASE_LAST) begin
               s_d.seq = SEQ_IDLE;
               s_d.busy = 1'b0;
               s_d.hreadyout = 1'b1;
            end
         end
         SEQ_PROG: begin
            mem_en = 1'b1;
            mem_we = 1'b1;
            mem_addr = {s_q.buf_row, s_q.cnt[WORD_W-1:0]};
            mem_wdata = s_q.pbuf[s_q.cnt[WORD_W-1:0]];
            s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt == PROG_LAST) begin
               s_d.seq = SEQ_IDLE;
               s_d.busy = 1'b0;
               s_d.hreadyout = 1'b1;
               // buffer returns to erased so a stale row is not reprogrammed
               s_d.pbuf = {`FL_WORDS{`FL_ERASED}};
            end
         end
      endcase
      s_d.lock = s_d.lock | s_q.lock;
      s_d.hresp = 1'b0;
   end

   // array contents are not reset; control state, page buffer and the memory's read register are
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   flash_mem #(
      .DW(`FL_DATA_W),
      .AW(WIDX_W)
   ) u_mem (
      .clk(clk),
      .resetn(resetn),
      .en(mem_en),
      .we(mem_we),
      .clr(mem_clr),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata_q(hrdata)
   );

   // read data come from the memory's own read register
   assign hreadyout = s_q.hreadyout;
   assign hresp = s_q.hresp;
   assign busy = s_q.busy;
   assign prot_state = s_q.prot;
   assign lock_state = s_q.lock;
endmodule // flash_array_access_control

// file: logic/flash_cfg.svh
// constants of the program flash access block: geometry, field positions, reset values
// assumes: included by bare name from the package and the design modules
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH
`define FL_SECTORS 32
`define FL_USABLE_SECTORS 30
`define FL_ROWS 16
`define FL_WORDS 16
`define FL_DATA_W 32
`define FL_ERASED 32'hffffffff
`define FL_PROT_RESET 32'hffffffff
`define FL_LOCK_RESET 32'h00000000
`define FL_WORD_LSB 2
`define FL_ADDR_W 15
`endif

// file: logic/flash_pkg.sv
// types of the program flash access block
// assumes: flash_cfg.svh on the include path
`include "flash_cfg.svh"
package flash_pkg;
   localparam int SECT_W = $clog2(`FL_SECTORS);
   localparam int ROW_W = $clog2(`FL_ROWS);
   localparam int WORD_W = $clog2(`FL_WORDS);
   localparam int CNT_W = ROW_W + WORD_W;
   localparam int WIDX_W = SECT_W + CNT_W;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_UNPROTECT,
      OP_PROTECT,
      OP_LOCK,
      OP_ERASE,
      OP_PROGRAM
   } op_t;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_ERASE,
      SEQ_PROG
   } seq_t;

   typedef struct packed {
      logic valid;
      op_t op;
      logic [SECT_W-1:0] sector;
   } cmd_t;

   typedef struct packed {
      seq_t seq;
      logic [CNT_W-1:0] cnt;
      logic [SECT_W-1:0] sector;
      logic [`FL_SECTORS-1:0] prot;
      logic [`FL_SECTORS-1:0] lock;
      logic busy;
      logic hreadyout;
      logic hresp;
      logic dph_act;
      logic dph_wr;
      logic [WIDX_W-1:0] dph_addr;
      logic [3:0] dph_be;
      logic [SECT_W+ROW_W-1:0] buf_row;
      logic [`FL_WORDS-1:0][`FL_DATA_W-1:0] pbuf;
   } state_t;
endpackage

// file: logic/flash_mem.sv
// single-port word memory holding the flash array contents
// assumes: one access per cycle; writes leave the read register untouched
module flash_mem #(
   parameter int DW = 32,
   parameter int AW = 13
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic en,
   input wire logic we,
   input wire logic clr,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata_q
);
   logic [DW-1:0] mem [2**AW];

   if (AW < 1 || DW < 8) begin : g_chk
      $error("flash_mem: unsupported geometry");
   end

   always_ff @(posedge clk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
   end

   // read register holds its value across sequencer writes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= '0;
      end else if (en && !we) begin
         rdata_q <= clr ? '0 : mem[addr];
      end
   end
endmodule // flash_mem

// file: verification/flash_props.sv
// concurrent checks on the flash access block's ports
// assumes: flash_cfg.svh and flash_pkg compiled first; bound below
`include "flash_cfg.svh"
module flash_props
   import flash_pkg::*;
#(
   parameter int USABLE_SECTORS = `FL_USABLE_SECTORS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire cmd_t cmd,
   input wire logic hresp,
   input wire logic hreadyout,
   input wire logic busy,
   input wire logic [`FL_SECTORS-1:0] prot_state,
   input wire logic [`FL_SECTORS-1:0] lock_state
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [8:0] run_q;
   logic go;
   logic ok;
   assign go = cmd.valid && !busy;
   assign ok = !prot_state[cmd.sector] && !lock_state[cmd.sector] && cmd.sector < USABLE_SECTORS;
   // length of the current busy run
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         run_q <= '0;
      end else begin
         run_q <= busy ? run_q + 9'h1 : 9'h0;
      end
   end
   AST_RESET_PROT: assert property (!$past(resetn) |-> prot_state == '1 && lock_state == '0)
      else $error("bad state after reset");
   AST_LOCK_STICKY: assert property ((lock_state & $past(lock_state)) == $past(lock_state))
      else $error("lock bit cleared");
   AST_NO_ERROR: assert property (hresp == 1'b0)
      else $error("error response");
   AST_BUSY_STALL: assert property (busy == !hreadyout)
      else $error("busy and ready disagree");
   AST_RUN_LEN: assert property ($fell(busy) |-> run_q == 9'h100 || run_q == 9'h010)
      else $error("bad busy length");
   AST_REFUSED: assert property (go && cmd.op == OP_ERASE && !ok |=> !busy)
      else $error("guarded sector erased");
   AST_ERASE_GO: assert property (go && cmd.op == OP_ERASE && ok |=> busy [*8])
      else $error("erase not started");
   AST_LOCK_SET: assert property (go && cmd.op == OP_LOCK |=> lock_state[$past(cmd.sector)])
      else $error("lock not set");
   COV_PROG: cover property (go && cmd.op == OP_PROGRAM);
   COV_ERASE: cover property ($fell(busy) && run_q == 9'h100);
   COV_LOCK: cover property (go && cmd.op == OP_LOCK);
endmodule // flash_props
bind flash_array_access_control flash_props #(.USABLE_SECTORS(USABLE_SECTORS)) i_props (
   .clk(clk), .resetn(resetn), .cmd(cmd), .hresp(hresp), .hreadyout(hreadyout),
   .busy(busy), .prot_state(prot_state), .lock_state(lock_state));

// file: verification/ahb_mst.sv
// ahb-lite master and command source in the processor's place
// assumes: single slave, hready looped back from hreadyout
module ahb_mst
   import flash_pkg::*;
(
   input wire logic clk,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic busy,
   output logic hsel,
   output logic [14:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output cmd_t cmd
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
      cmd = '0;
   end
   task automatic xfer(input logic w, input logic [2:0] z, input logic [14:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= z;
      haddr <= a;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
      // released data lines must not look valid
      hwdata <= ~d;
   endtask
   task automatic issue(input op_t o, input logic [4:0] s);
      // spare edge keeps the strobe low between back-to-back commands
      @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
      cmd <= '{1'b1, o, s};
      @(posedge clk);
      cmd <= '0;
   endtask
endmodule // ahb_mst

// file: verification/flash_array_access_control_test.sv
// self-checking bench of the flash access block
// assumes: master model and checker compiled before
`include "flash_cfg.svh"
module flash_array_access_control_test import flash_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, resetn, hsel, hwrite, hreadyout, hresp, busy;
   logic [14:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, prot_state, lock_state;
   cmd_t cmd;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   flash_array_access_control i_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .cmd(cmd), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .busy(busy),
      .prot_state(prot_state), .lock_state(lock_state));
   ahb_mst i_mst (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata), .busy(busy), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .cmd(cmd));
   task automatic give_verdict();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         $display("Error at %0t: got %h expected %h", $time, g, e);
         fail_count++;
      end
   endtask
   // busy cycles of the operation just issued
   task automatic run_len(output int n);
      n = 0;
      repeat (300) begin
         @(posedge clk);
         if (busy !== 1'b1) break;
         n++;
      end
   endtask
   task automatic t_reset();
      int n;
      chk(prot_state, `FL_PROT_RESET);
      chk(lock_state, `FL_LOCK_RESET);
      i_mst.issue(OP_ERASE, 5'h5);
      run_len(n);
      chk(n, 0);
   endtask
   task automatic t_modify();
      logic [31:0] r;
      int n;
      i_mst.issue(OP_UNPROTECT, 5'h3);
      i_mst.issue(OP_ERASE, 5'h3);
      run_len(n);
      chk(n, 256);
      i_mst.xfer(1'b0, 3'h2, 15'h0c84, '0, r);
      chk(r, `FL_ERASED);
      i_mst.xfer(1'b1, 3'h2, 15'h0c84, 32'h44332211, r);
      i_mst.xfer(1'b1, 3'h0, 15'h0c89, 32'h00005a00, r);
      i_mst.xfer(1'b1, 3'h1, 15'h0c8e, 32'hbeef0000, r);
      i_mst.xfer(1'b0, 3'h2, 15'h0c84, '0, r);
      chk(r, `FL_ERASED);
      i_mst.issue(OP_PROGRAM, 5'h3);
      run_len(n);
      chk(n, 16);
      i_mst.xfer(1'b0, 3'h2, 15'h0c84, '0, r);
      chk(r, 32'h44332211);
      i_mst.xfer(1'b0, 3'h2, 15'h0c88, '0, r);
      chk(r, 32'hffff5aff);
      i_mst.xfer(1'b0, 3'h2, 15'h0c8c, '0, r);
      chk(r, 32'hbeefffff);
   endtask
   task automatic t_lock();
      logic [31:0] r;
      int n;
      i_mst.issue(OP_LOCK, 5'h3);
      @(posedge clk);
      chk(lock_state, 32'h8);
      i_mst.issue(OP_ERASE, 5'h3);
      run_len(n);
      chk(n, 0);
      i_mst.xfer(1'b0, 3'h2, 15'h0c84, '0, r);
      chk(r, 32'h44332211);
      i_mst.issue(OP_PROTECT, 5'h3);
      // buffer row in sector 4, which was never unprotected
      i_mst.xfer(1'b1, 3'h2, 15'h1004, 32'h0, r);
      i_mst.issue(OP_PROGRAM, 5'h4);
      run_len(n);
      chk(n, 0);
      i_mst.issue(OP_UNPROTECT, 5'h1e);
      i_mst.issue(OP_ERASE, 5'h1e);
      run_len(n);
      chk(n, 0);
      chk(prot_state, 32'hbfffffff);
      i_mst.xfer(1'b0, 3'h2, 15'h7800, '0, r);
      chk(r, 32'h0);
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ceiling well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      resetn = 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_modify();
      t_lock();
      give_verdict();
   end
endmodule // flash_array_access_control_test
